/* File: shared/osdr_pkg.sv */
// Constants and types for the display control register set
package osdr_pkg;

    // ========================================
    // Bus geometry
    localparam int ADR_W = 12;
    localparam int DAT_W = 32;
    localparam int BANK_HI = 11;
    localparam int BANK_LO = 10;
    localparam int IDX_HI = 9;
    localparam int IDX_LO = 2;

    // ========================================
    // Register banks (address bits 11:10)
    localparam logic [1:0] BANK_SYSTEM = 2'h0;
    localparam logic [1:0] BANK_DISPLAY = 2'h1;
    localparam logic [1:0] BANK_COLOUR = 2'h2;

    // ========================================
    // Register indices within a bank
    localparam logic [7:0] IDX_DEFAULT_COLOUR = 8'hf0;
    localparam logic [7:0] IDX_CURSOR_ABSOLUTE_ROW = 8'hf1;
    localparam logic [7:0] IDX_PAGE_LOCATION_POINTER = 8'hf6;
    localparam logic [7:0] IDX_HEADER_STATUS_LOCATION_POINTER = 8'hf7;
    localparam logic [7:0] IDX_DISPLAY_MODE_SECOND = 8'hfb;
    localparam logic [7:0] IDX_TEXT_RAM_COMBINED_POINTER = 8'hfc;
    localparam logic [7:0] IDX_ROW_ENABLE_LOW = 8'hfd;
    localparam logic [7:0] IDX_ROW_ENABLE_MID = 8'hfe;
    localparam logic [7:0] IDX_ROW_ENABLE_HIGH = 8'hff;
    localparam logic [7:0] IDX_SCREEN_SHIFT_CONTROL = 8'hff;

    // ========================================
    // Field positions
    localparam int MODE_EXTERNAL_FONT_SELECT_BIT = 3;
    localparam int MODE_BLANK_LEVEL_BIT = 2;
    localparam int MODE_LINE_BIT = 1;
    localparam int MODE_TWO_BYTE_BIT = 0;
    localparam int NIBBLE_HI_LSB = 4;
    localparam int SHIFT_BIT = 6;
    localparam int CURSOR_W = 5;
    localparam int ROWS_LOW_W = 8;
    localparam int ROWS_HIGH_W = 7;
    localparam int ROW_COUNT = 23;

    // ========================================
    // Reset values
    localparam logic [7:0] RST_DEFAULT_COLOUR = 8'h70;
    localparam logic [3:0] RST_MODE = 4'h0;
    localparam logic [3:0] RST_POINTER = 4'h0;
    localparam logic [4:0] RST_CURSOR = 5'h00;
    localparam logic [22:0] RST_ROW_ENABLE = 23'h7fffff;
    localparam logic RST_SHIFT = 1'b0;

    // ========================================
    // Screen geometry
    localparam logic [4:0] HEADER_ROW = 5'h00;
    localparam logic [4:0] LAST_TEXT_ROW = 5'h17;
    localparam logic [4:0] LAST_STATUS_ROW = 5'h19;
    localparam logic [4:0] LINE_MODE_ROWS = 5'h0c;
    localparam logic [1:0] BYTES_SERIAL = 2'h1;
    localparam logic [1:0] BYTES_PARALLEL = 2'h2;

    // ========================================
    // Gun drive levels
    localparam logic [1:0] GUN_OFF = 2'h0;
    localparam logic [1:0] GUN_HALF = 2'h1;
    localparam logic [1:0] GUN_FULL = 2'h2;

    // External font switch only exists in an emulation build
    localparam logic EMULATION_BUILD = 1'b0;

    typedef enum logic [3:0]
    {
        SEL_NONE,
        SEL_COLOUR,
        SEL_CURSOR,
        SEL_PAGE_PTR,
        SEL_HS_PTR,
        SEL_MODE,
        SEL_COMBINED,
        SEL_ROWS_LOW,
        SEL_ROWS_MID,
        SEL_ROWS_HIGH,
        SEL_SHIFT
    } osdr_sel_t;

endpackage

/* File: shared/osdr_row_if.sv */
// Row lookup signals between register bank and row mapper
`timescale 1ns/100ps
interface osdr_row_if;
    logic line_mode;
    logic two_byte;
    logic [4:0] text_row;
    logic [4:0] attr_row;
    logic [22:0] row_en;
    logic visible;
    logic [4:0] screen_row;
    logic [1:0] fetch_bytes;

    modport bank
    (
        output line_mode,
        output two_byte,
        output text_row,
        output attr_row,
        output row_en,
        input visible,
        input screen_row,
        input fetch_bytes
    );

    modport mapper
    (
        input line_mode,
        input two_byte,
        input text_row,
        input attr_row,
        input row_en,
        output visible,
        output screen_row,
        output fetch_bytes
    );
endinterface

/* File: hdl/osdr_row_mapper.sv */
// Row visibility, screen placement and fetch width lookup
`timescale 1ns/100ps
module osdr_row_mapper
(
    osdr_row_if.mapper rif
);

    // ========================================
    // Lookup
    always_comb
    begin
        rif.visible = 1'b0;
        rif.screen_row = rif.text_row;
        if (rif.line_mode)
        begin
            // Up to twelve rows placed by row attribute
            rif.visible = (rif.text_row < osdr_pkg::LINE_MODE_ROWS);
            rif.screen_row = rif.attr_row;
        end
        else if (rif.text_row == osdr_pkg::HEADER_ROW)
        begin
            rif.visible = 1'b1;
        end
        else if (rif.text_row <= osdr_pkg::LAST_TEXT_ROW)
        begin
            rif.visible = rif.row_en[rif.text_row - 5'h01];
        end
        else if (rif.text_row <= osdr_pkg::LAST_STATUS_ROW)
        begin
            rif.visible = 1'b1;
        end
        rif.fetch_bytes = rif.two_byte ? osdr_pkg::BYTES_PARALLEL
                                       : osdr_pkg::BYTES_SERIAL;
    end

endmodule

/* File: hdl/osdr_regs.sv */
// Display control register bank with Wishbone slave
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/100ps
module osdr_regs
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [osdr_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [osdr_pkg::DAT_W-1:0] wb_dat_i,
    output logic [osdr_pkg::DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic osd_active_i,
    input wire logic osd_translucent_i,
    input wire logic [4:0] text_row_i,
    input wire logic [4:0] row_attr_i,
    output logic fast_blank_output_o,
    output logic translucency_output_o,
    output logic external_font_select_o,
    output logic line_mode_select_o,
    output logic two_byte_coding_select_o,
    output logic [3:0] header_status_location_o,
    output logic [3:0] page_location_o,
    output logic [22:0] row_enable_o,
    output logic [3:0] default_foreground_o,
    output logic [3:0] default_background_o,
    output logic [5:0] fg_guns_o,
    output logic fg_half_o,
    output logic [5:0] bg_guns_o,
    output logic bg_half_o,
    output logic [4:0] cursor_absolute_row_value_o,
    output logic right_screen_shift_o,
    output logic row_visible_o,
    output logic [4:0] screen_row_o,
    output logic [1:0] fetch_bytes_o
);

    // ========================================
    // Helpers
    function automatic osdr_pkg::osdr_sel_t decode_sel(input logic [osdr_pkg::ADR_W-1:0] adr);
        logic [1:0] bank;
        logic [7:0] idx;
        bank = adr[osdr_pkg::BANK_HI:osdr_pkg::BANK_LO];
        idx = adr[osdr_pkg::IDX_HI:osdr_pkg::IDX_LO];
        decode_sel = osdr_pkg::SEL_NONE;
        if (adr[1:0] == 2'h0)
        begin
            unique case (bank)
                osdr_pkg::BANK_SYSTEM:
                begin
                    if (idx == osdr_pkg::IDX_SCREEN_SHIFT_CONTROL)
                        decode_sel = osdr_pkg::SEL_SHIFT;
                end
                osdr_pkg::BANK_DISPLAY:
                begin
                    if (idx == osdr_pkg::IDX_DISPLAY_MODE_SECOND)
                        decode_sel = osdr_pkg::SEL_MODE;
                    else if (idx == osdr_pkg::IDX_TEXT_RAM_COMBINED_POINTER)
                        decode_sel = osdr_pkg::SEL_COMBINED;
                    else if (idx == osdr_pkg::IDX_ROW_ENABLE_LOW)
                        decode_sel = osdr_pkg::SEL_ROWS_LOW;
                    else if (idx == osdr_pkg::IDX_ROW_ENABLE_MID)
                        decode_sel = osdr_pkg::SEL_ROWS_MID;
                    else if (idx == osdr_pkg::IDX_ROW_ENABLE_HIGH)
                        decode_sel = osdr_pkg::SEL_ROWS_HIGH;
                end
                osdr_pkg::BANK_COLOUR:
                begin
                    if (idx == osdr_pkg::IDX_DEFAULT_COLOUR)
                        decode_sel = osdr_pkg::SEL_COLOUR;
                    else if (idx == osdr_pkg::IDX_CURSOR_ABSOLUTE_ROW)
                        decode_sel = osdr_pkg::SEL_CURSOR;
                    else if (idx == osdr_pkg::IDX_PAGE_LOCATION_POINTER)
                        decode_sel = osdr_pkg::SEL_PAGE_PTR;
                    else if (idx == osdr_pkg::IDX_HEADER_STATUS_LOCATION_POINTER)
                        decode_sel = osdr_pkg::SEL_HS_PTR;
                end
                default:
                begin
                    decode_sel = osdr_pkg::SEL_NONE;
                end
            endcase
        end
    endfunction

    // Code bits are half, red, green, blue; guns are red, green, blue
    function automatic logic [6:0] colour_levels(input logic [3:0] code);
        logic [1:0] lvl;
        lvl = code[3] ? osdr_pkg::GUN_HALF : osdr_pkg::GUN_FULL;
        colour_levels = {code[3],
                         code[2] ? lvl : osdr_pkg::GUN_OFF,
                         code[1] ? lvl : osdr_pkg::GUN_OFF,
                         code[0] ? lvl : osdr_pkg::GUN_OFF};
    endfunction

    // ========================================
    // Register state
    logic [7:0] colour_reg;
    logic [7:0] colour_next;
    logic [4:0] cursor_reg;
    logic [4:0] cursor_next;
    logic [3:0] page_ptr_reg;
    logic [3:0] page_ptr_next;
    logic [3:0] hs_ptr_reg;
    logic [3:0] hs_ptr_next;
    logic [3:0] mode_reg;
    logic [3:0] mode_next;
    logic [22:0] rows_reg;
    logic [22:0] rows_next;
    logic shift_reg;
    logic shift_next;
    logic ack_reg;
    logic ack_next;
    logic [osdr_pkg::DAT_W-1:0] rdata_reg;
    logic [osdr_pkg::DAT_W-1:0] rdata_next;
    osdr_pkg::osdr_sel_t sel;
    logic wr_en;
    logic [7:0] wbyte;
    logic [7:0] rbyte;

    assign sel = decode_sel(wb_adr_i);
    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg && wb_sel_i[0];
    assign wbyte = wb_dat_i[7:0];

    // ========================================
    // Read multiplexer
    always_comb
    begin
        rbyte = 8'h00;
        unique case (sel)
            osdr_pkg::SEL_COLOUR: rbyte = colour_reg;
            osdr_pkg::SEL_CURSOR: rbyte = {3'h0, cursor_reg};
            osdr_pkg::SEL_PAGE_PTR: rbyte = {4'h0, page_ptr_reg};
            osdr_pkg::SEL_HS_PTR: rbyte = {4'h0, hs_ptr_reg};
            osdr_pkg::SEL_MODE: rbyte = {4'h0, mode_reg};
            osdr_pkg::SEL_COMBINED: rbyte = {hs_ptr_reg, page_ptr_reg};
            osdr_pkg::SEL_ROWS_LOW: rbyte = rows_reg[7:0];
            osdr_pkg::SEL_ROWS_MID: rbyte = rows_reg[15:8];
            osdr_pkg::SEL_ROWS_HIGH: rbyte = {1'b0, rows_reg[22:16]};
            osdr_pkg::SEL_SHIFT: rbyte = {1'b0, shift_reg, 6'h00};
            osdr_pkg::SEL_NONE: rbyte = 8'h00;
        endcase
    end

    // ========================================
    // Next-state for registers and bus answer
    always_comb
    begin
        colour_next = colour_reg;
        cursor_next = cursor_reg;
        page_ptr_next = page_ptr_reg;
        hs_ptr_next = hs_ptr_reg;
        mode_next = mode_reg;
        rows_next = rows_reg;
        shift_next = shift_reg;
        ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
        rdata_next = rdata_reg;
        if (wb_cyc_i && wb_stb_i && !ack_reg)
        begin
            rdata_next = {{(osdr_pkg::DAT_W-8){1'b0}}, rbyte};
        end
        if (wr_en)
        begin
            unique case (sel)
                osdr_pkg::SEL_COLOUR:
                begin
                    colour_next = wbyte;
                end
                osdr_pkg::SEL_CURSOR:
                begin
                    cursor_next = wbyte[osdr_pkg::CURSOR_W-1:0];
                end
                osdr_pkg::SEL_PAGE_PTR:
                begin
                    page_ptr_next = wbyte[3:0];
                end
                osdr_pkg::SEL_HS_PTR:
                begin
                    hs_ptr_next = wbyte[3:0];
                end
                osdr_pkg::SEL_MODE:
                begin
                    mode_next = wbyte[3:0];
                end
                osdr_pkg::SEL_COMBINED:
                begin
                    hs_ptr_next = wbyte[7:osdr_pkg::NIBBLE_HI_LSB];
                    page_ptr_next = wbyte[3:0];
                end
                osdr_pkg::SEL_ROWS_LOW:
                begin
                    rows_next[7:0] = wbyte;
                end
                osdr_pkg::SEL_ROWS_MID:
                begin
                    rows_next[15:8] = wbyte;
                end
                osdr_pkg::SEL_ROWS_HIGH:
                begin
                    rows_next[22:16] = wbyte[osdr_pkg::ROWS_HIGH_W-1:0];
                end
                osdr_pkg::SEL_SHIFT:
                begin
                    shift_next = wbyte[osdr_pkg::SHIFT_BIT];
                end
                osdr_pkg::SEL_NONE:
                begin
                    shift_next = shift_reg;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            colour_reg <= osdr_pkg::RST_DEFAULT_COLOUR;
            cursor_reg <= osdr_pkg::RST_CURSOR;
            page_ptr_reg <= osdr_pkg::RST_POINTER;
            hs_ptr_reg <= osdr_pkg::RST_POINTER;
            mode_reg <= osdr_pkg::RST_MODE;
            rows_reg <= osdr_pkg::RST_ROW_ENABLE;
            shift_reg <= osdr_pkg::RST_SHIFT;
            ack_reg <= 1'b0;
            rdata_reg <= '0;
        end
        else if (ce_i)
        begin
            colour_reg <= colour_next;
            cursor_reg <= cursor_next;
            page_ptr_reg <= page_ptr_next;
            hs_ptr_reg <= hs_ptr_next;
            mode_reg <= mode_next;
            rows_reg <= rows_next;
            shift_reg <= shift_next;
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    // ========================================
    // Row lookup
    osdr_row_if rif ();

    assign rif.line_mode = mode_reg[osdr_pkg::MODE_LINE_BIT];
    assign rif.two_byte = mode_reg[osdr_pkg::MODE_TWO_BYTE_BIT];
    assign rif.text_row = text_row_i;
    assign rif.attr_row = row_attr_i;
    assign rif.row_en = rows_reg;

    osdr_row_mapper u_mapper
    (
        .rif(rif.mapper)
    );

    // ========================================
    // Display outputs; blank, translucency and row lookup registered
    logic blank_reg;
    logic blank_next;
    logic transl_reg;
    logic transl_next;
    logic vis_reg;
    logic vis_next;
    logic [4:0] srow_reg;
    logic [4:0] srow_next;
    logic [1:0] fetch_reg;
    logic [1:0] fetch_next;
    logic [6:0] fg_lv;
    logic [6:0] bg_lv;

    always_comb
    begin
        blank_next = osd_active_i ~^ mode_reg[osdr_pkg::MODE_BLANK_LEVEL_BIT];
        transl_next = osd_translucent_i ~^ mode_reg[osdr_pkg::MODE_BLANK_LEVEL_BIT];
        vis_next = rif.visible;
        srow_next = rif.screen_row;
        fetch_next = rif.fetch_bytes;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            blank_reg <= 1'b0;
            transl_reg <= 1'b0;
            vis_reg <= 1'b0;
            srow_reg <= osdr_pkg::HEADER_ROW;
            fetch_reg <= osdr_pkg::BYTES_SERIAL;
        end
        else if (ce_i)
        begin
            blank_reg <= blank_next;
            transl_reg <= transl_next;
            vis_reg <= vis_next;
            srow_reg <= srow_next;
            fetch_reg <= fetch_next;
        end
    end

    assign fg_lv = colour_levels(colour_reg[7:osdr_pkg::NIBBLE_HI_LSB]);
    assign bg_lv = colour_levels(colour_reg[3:0]);

    assign fast_blank_output_o = blank_reg;
    assign translucency_output_o = transl_reg;
    assign external_font_select_o = mode_reg[osdr_pkg::MODE_EXTERNAL_FONT_SELECT_BIT]
                                    & osdr_pkg::EMULATION_BUILD;
    assign line_mode_select_o = mode_reg[osdr_pkg::MODE_LINE_BIT];
    assign two_byte_coding_select_o = mode_reg[osdr_pkg::MODE_TWO_BYTE_BIT];
    assign header_status_location_o = hs_ptr_reg;
    assign page_location_o = page_ptr_reg;
    assign row_enable_o = rows_reg;
    assign default_foreground_o = colour_reg[7:osdr_pkg::NIBBLE_HI_LSB];
    assign default_background_o = colour_reg[3:0];
    assign fg_guns_o = fg_lv[5:0];
    assign fg_half_o = fg_lv[6];
    assign bg_guns_o = bg_lv[5:0];
    assign bg_half_o = bg_lv[6];
    assign cursor_absolute_row_value_o = cursor_reg;
    assign right_screen_shift_o = shift_reg;
    assign row_visible_o = vis_reg;
    assign screen_row_o = srow_reg;
    assign fetch_bytes_o = fetch_reg;

endmodule

/* File: test/osdr_regs_properties.sv */
// Concurrent checks on the display control register bank ports
`timescale 1ns/100ps
module osdr_regs_properties
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [osdr_pkg::DAT_W-1:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic osd_active_i,
    input wire logic osd_translucent_i,
    input wire logic [4:0] text_row_i,
    input wire logic [4:0] row_attr_i,
    input wire logic fast_blank_output_o,
    input wire logic translucency_output_o,
    input wire logic external_font_select_o,
    input wire logic line_mode_select_o,
    input wire logic two_byte_coding_select_o,
    input wire logic [22:0] row_enable_o,
    input wire logic [3:0] default_foreground_o,
    input wire logic [5:0] fg_guns_o,
    input wire logic fg_half_o,
    input wire logic row_visible_o,
    input wire logic [4:0] screen_row_o,
    input wire logic [1:0] fetch_bytes_o
);
    // ========================================
    // Expected lookups
    logic exp_vis;
    logic [5:0] exp_fg;

    always_comb
    begin
        exp_vis = 1'b1;
        if (text_row_i != 5'h00 && text_row_i < 5'h18)
            exp_vis = row_enable_o[text_row_i - 5'h01];
        for (int i = 0; i < 3; i++)
            exp_fg[2*i +: 2] = !default_foreground_o[i] ? osdr_pkg::GUN_OFF :
                default_foreground_o[3] ? osdr_pkg::GUN_HALF : osdr_pkg::GUN_FULL;
    end

    // ========================================
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    chk_ack_single: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    chk_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    chk_font_off: assert property (!external_font_select_o)
        else $error("font select active in production build");
    chk_blank_match: assert property (ce_i && osd_active_i == osd_translucent_i |=>
        fast_blank_output_o == translucency_output_o)
        else $error("blank and translucency polarity differ");
    chk_fetch_width: assert property (ce_i |=> fetch_bytes_o == ($past(two_byte_coding_select_o) ?
        osdr_pkg::BYTES_PARALLEL : osdr_pkg::BYTES_SERIAL))
        else $error("fetch width does not follow coding bit");
    chk_page_visible: assert property (ce_i && !line_mode_select_o && text_row_i < 5'h1a |=>
        row_visible_o == $past(exp_vis))
        else $error("full page row visibility wrong");
    chk_line_place: assert property (ce_i && line_mode_select_o && text_row_i < 5'h0c |=>
        row_visible_o && screen_row_o == $past(row_attr_i))
        else $error("line mode row placement wrong");
    chk_line_hidden: assert property (ce_i && line_mode_select_o && text_row_i >= 5'h0c |=>
        !row_visible_o)
        else $error("line mode row beyond twelve shown");
    chk_colour_code: assert property (!$past(reset_i) && $past(ce_i) &&
        $stable(default_foreground_o) |-> fg_guns_o == exp_fg && fg_half_o == default_foreground_o[3])
        else $error("foreground colour decode wrong");

    cover property (line_mode_select_o && row_visible_o);
    cover property (fetch_bytes_o == osdr_pkg::BYTES_PARALLEL);
    cover property (fast_blank_output_o && !translucency_output_o);
endmodule

bind osdr_regs osdr_regs_properties chk_u
(
    .clk_i, .reset_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .osd_active_i,
    .osd_translucent_i, .text_row_i, .row_attr_i, .fast_blank_output_o, .translucency_output_o,
    .external_font_select_o, .line_mode_select_o, .two_byte_coding_select_o, .row_enable_o,
    .default_foreground_o, .fg_guns_o, .fg_half_o, .row_visible_o, .screen_row_o, .fetch_bytes_o
);

/* File: test/osdr_regs_tb.sv */
// Self-checking bench for the display control register bank
`timescale 1ns/100ps
module osdr_regs_tb;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic ce_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [11:0] wb_adr_i = 12'h000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic osd_active_i = 1'b0;
    logic osd_translucent_i = 1'b0;
    logic [4:0] text_row_i = 5'h00;
    logic [4:0] row_attr_i = 5'h00;
    logic [31:0] wb_dat_o;
    logic [31:0] rdata;
    logic wb_ack_o, fast_blank_output_o, translucency_output_o, external_font_select_o;
    logic line_mode_select_o, two_byte_coding_select_o, fg_half_o, bg_half_o;
    logic right_screen_shift_o, row_visible_o, fb_hold;
    logic [3:0] header_status_location_o, page_location_o, default_foreground_o;
    logic [3:0] default_background_o;
    logic [22:0] row_enable_o;
    logic [5:0] fg_guns_o, bg_guns_o;
    logic [4:0] cursor_absolute_row_value_o, screen_row_o;
    logic [1:0] fetch_bytes_o;
    int fail_count = 0;
    int checks = 0;

    // Addresses: bank in 11:10, index in 9:2
    localparam logic [11:0] A_COL = 12'hbc0, A_CUR = 12'hbc4, A_PG = 12'hbd8, A_HS = 12'hbdc;
    localparam logic [11:0] A_MODE = 12'h7ec, A_PTR = 12'h7f0, A_R0 = 12'h7f4, A_R1 = 12'h7f8;
    localparam logic [11:0] A_R2 = 12'h7fc, A_SH = 12'h3fc;
    localparam logic [22:0] ROWS_EXP = 23'h7f8001;
    logic [11:0] ta [10] = '{A_COL, A_CUR, A_PG, A_HS, A_MODE, A_PTR, A_R0, A_R1, A_R2, A_SH};
    logic [7:0] tr [10] = '{8'h70, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h7f, 8'h00};
    logic [7:0] tw [10] = '{8'h5a, 8'hff, 8'h09, 8'h06, 8'h0c, 8'hc3, 8'h01, 8'h80, 8'hff, 8'hff};
    logic [7:0] te [10] = '{8'h5a, 8'h1f, 8'h03, 8'h0c, 8'h0c, 8'hc3, 8'h01, 8'h80, 8'h7f, 8'h40};

    always #2 clk_i = ~clk_i;

    osdr_regs dut_u
    (
        .clk_i, .reset_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .osd_active_i, .osd_translucent_i, .text_row_i,
        .row_attr_i, .fast_blank_output_o, .translucency_output_o, .external_font_select_o,
        .line_mode_select_o, .two_byte_coding_select_o, .header_status_location_o,
        .page_location_o, .row_enable_o, .default_foreground_o, .default_background_o,
        .fg_guns_o, .fg_half_o, .bg_guns_o, .bg_half_o, .cursor_absolute_row_value_o,
        .right_screen_shift_o, .row_visible_o, .screen_row_o, .fetch_bytes_o
    );

    // ========================================
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic [11:0] a, input logic w, input logic [7:0] d, input logic [3:0] s);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= {24'h0, d};
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1)
            @(posedge clk_i);
        rdata = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        bus(a, 1'b1, d, 4'h1);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        bus(a, 1'b0, 8'h00, 4'h1);
        check(rdata, {24'h0, e});
    endtask

    task automatic look(input logic [4:0] r, input logic [4:0] att);
        @(posedge clk_i);
        text_row_i <= r;
        row_attr_i <= att;
        repeat (2) @(posedge clk_i);
    endtask

    function automatic logic [5:0] guns(input logic [3:0] c);
        logic [1:0] g;
        g = c[3] ? 2'h1 : 2'h2;
        return {c[2] ? g : 2'h0, c[1] ? g : 2'h0, c[0] ? g : 2'h0};
    endfunction

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ========================================
    // Tests
    initial
    begin
        repeat (5) @(posedge clk_i);
        reset_i <= 1'b0;
        for (int i = 0; i < 10; i++)
            rd(ta[i], tr[i]);
        for (int i = 0; i < 10; i++)
            wr(ta[i], tw[i]);
        for (int i = 0; i < 10; i++)
            rd(ta[i], te[i]);
        check(external_font_select_o, 1'b0);
        check(row_enable_o, ROWS_EXP);
        check({header_status_location_o, page_location_o}, 8'hc3);
        check({default_foreground_o, default_background_o}, 8'h5a);
        check({cursor_absolute_row_value_o, right_screen_shift_o}, 6'h3f);
        wr(A_PG, 8'h05);
        rd(A_PTR, 8'hc5);
        for (int r = 0; r < 26; r++)
        begin
            look(r[4:0], 5'h00);
            check(row_visible_o, (r == 0 || r > 23) ? 1'b1 : ROWS_EXP[r-1]);
        end
        wr(A_MODE, 8'h02);
        check(line_mode_select_o, 1'b1);
        for (int r = 0; r < 13; r++)
        begin
            look(r[4:0], 5'(25 - r));
            check({row_visible_o, screen_row_o}, {r < 12, 5'(25 - r)});
        end
        for (int i = 0; i < 8; i++)
        begin
            wr(A_MODE, {5'h00, i[2], 1'b0, i[0]});
            check({line_mode_select_o, two_byte_coding_select_o}, {1'b0, i[0]});
            osd_active_i <= i[1];
            osd_translucent_i <= !i[1];
            look(5'h01, 5'h00);
            check(fetch_bytes_o, i[0] ? 2'h2 : 2'h1);
            check({fast_blank_output_o, translucency_output_o}, {i[1] ~^ i[2], i[1] ^ i[2]});
        end
        fb_hold = fast_blank_output_o;
        ce_i <= 1'b0;
        osd_active_i <= !osd_active_i;
        repeat (3) @(posedge clk_i);
        check(fast_blank_output_o, fb_hold);
        ce_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        check(fast_blank_output_o, !fb_hold);
        for (int c = 0; c < 16; c++)
        begin
            wr(A_COL, {c[3:0], ~c[3:0]});
            repeat (2) @(posedge clk_i);
            check({fg_half_o, fg_guns_o}, {c[3], guns(c[3:0])});
            check({bg_half_o, bg_guns_o}, {!c[3], guns(~c[3:0])});
        end
        wr(12'hfc0, 8'hff);
        rd(12'hfc0, 8'h00);
        bus(A_COL, 1'b1, 8'h11, 4'he);
        bus(A_COL | 12'h001, 1'b1, 8'h22, 4'h1);
        rd(A_COL, 8'hf0);
        @(posedge clk_i);
        reset_i <= 1'b1;
        @(posedge clk_i);
        reset_i <= 1'b0;
        rd(A_R2, 8'h7f);
        rd(A_COL, 8'h70);
        final_report;
    end

    // Tests need well under 2000 cycles
    initial
    begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        final_report;
    end
endmodule
